// *** core/adcseq_pkg.sv ***
// shared constants and types of the result word and channel sequencer
package adcseq_pkg;

  // ----------------------------------------------------------------
  // result word layout
  // ----------------------------------------------------------------
  localparam int RESULT_W = 18;
  localparam int WORD_W = 24;
  localparam int TAG_W = 3;
  localparam int RAW_W_DEF = 20;
  localparam int RESULT_LSB = 6;
  localparam int RESERVED_BIT = 5;
  localparam int AUX_HIGH_BIT = 4;
  localparam int AUX_LOW_BIT = 3;
  localparam int TAG_LSB = 0;
  localparam logic [RESULT_W-1:0] RESULT_MAX = 18'h3FFFF;
  localparam logic [RESULT_W-1:0] RESULT_MIN = 18'h00000;
  localparam logic [WORD_W-1:0] WORD_RESET = 24'h000000;
  localparam logic [4:0] WRITE_BITS = 5'h08;
  localparam logic [4:0] READ_BITS = 5'h18;

  // ----------------------------------------------------------------
  // channel tags and input pin codes
  // ----------------------------------------------------------------
  localparam logic [TAG_W-1:0] TAG_CAL = 3'h7;
  localparam logic [TAG_W-1:0] TAG_D12 = 3'h4;
  localparam logic [TAG_W-1:0] TAG_D34 = 3'h5;
  localparam logic [TAG_W-1:0] TAG_D56 = 3'h6;
  localparam logic [2:0] PIN_AIN1 = 3'h0;
  localparam logic [2:0] PIN_AIN2 = 3'h1;
  localparam logic [2:0] PIN_AIN3 = 3'h2;
  localparam logic [2:0] PIN_AIN4 = 3'h3;
  localparam logic [2:0] PIN_AIN5 = 3'h4;
  localparam logic [2:0] PIN_COMMON = 3'h5;
  localparam logic [2:0] PIN_CAL_OFF = 3'h6;
  localparam logic [2:0] PIN_CAL_GAIN = 3'h7;
  localparam logic [1:0] MODE_OFFSET = 2'h1;
  localparam logic [1:0] MODE_GAIN = 2'h2;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int SETTLE_BASE_NS = 4000;
  localparam int SETTLE_BASE_CYC = (SETTLE_BASE_NS * CLK_MHZ + 999) / 1000;

  typedef enum logic [3:0] {
    CH_P1 = 4'h0, CH_P2 = 4'h1, CH_P3 = 4'h2, CH_P4 = 4'h3, CH_P5 = 4'h4,
    CH_D12 = 4'h5, CH_D34 = 4'h6, CH_D56 = 4'h7,
    CH_COFF = 4'h8, CH_CGAIN = 4'h9
  } adcseq_chan_t;

  typedef enum logic [0:0] {
    SQ_SETTLE = 1'b0,
    SQ_SAMPLE = 1'b1
  } adcseq_seq_t;

  typedef enum logic [1:0] {
    SH_IDLE = 2'b00,
    SH_READ = 2'b01,
    SH_WRITE = 2'b10
  } adcseq_shift_t;

endpackage

// *** core/adcseq_shifter.sv ***
// serial engine: shifts the result word out, swallows ignored writes
`timescale 1ns/1ps
module adcseq_shifter
  import adcseq_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic enable_in,
  // requests
  input wire logic load_read_in,
  input wire logic load_write_in,
  input wire logic [WORD_W-1:0] word_in,
  input wire logic [1:0] aux_in,
  // serial clock edges, already filtered
  input wire logic sclk_fall_in,
  input wire logic sclk_rise_in,
  // serial side
  output logic dout_out,
  output logic busy_out,
  output logic done_out
);

  adcseq_shift_t state;
  logic [WORD_W-1:0] shreg;
  logic [4:0] count;
  logic first_fall;
  logic [WORD_W-1:0] with_aux;

  always_comb
  begin
    with_aux = shreg;
    if (first_fall)
    begin
      with_aux[RESERVED_BIT] = 1'b0;
      with_aux[AUX_HIGH_BIT] = aux_in[1];
      with_aux[AUX_LOW_BIT] = aux_in[0];
    end
  end

  // ----------------------------------------------------------------
  // shift engine
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      state <= SH_IDLE;
      shreg <= WORD_RESET;
      count <= 5'h00;
      first_fall <= 1'b0;
      dout_out <= 1'b0;
      done_out <= 1'b0;
    end
    else if (enable_in)
    begin
      done_out <= 1'b0;
      unique case (state)
        SH_IDLE:
        begin
          count <= 5'h00;
          if (load_read_in)
          begin
            shreg <= word_in;
            dout_out <= word_in[WORD_W-1];
            first_fall <= 1'b1;
            state <= SH_READ;
          end
          else if (load_write_in)
            state <= SH_WRITE;
        end
        SH_READ:
          if (sclk_fall_in)
          begin
            first_fall <= 1'b0;
            shreg <= {with_aux[WORD_W-2:0], 1'b0};
            dout_out <= with_aux[WORD_W-2];
            count <= count + 5'h01;
            if (count == READ_BITS - 5'h01)
            begin
              state <= SH_IDLE;
              done_out <= 1'b1;
            end
          end
        SH_WRITE:
          // eight bits are clocked in and dropped
          if (sclk_rise_in)
          begin
            count <= count + 5'h01;
            if (count == WRITE_BITS - 5'h01)
            begin
              state <= SH_IDLE;
              done_out <= 1'b1;
            end
          end
        default:
          state <= SH_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      busy_out <= 1'b0;
    else if (enable_in)
      busy_out <= (state == SH_IDLE) ? (load_read_in | load_write_in)
        : !(done_out == 1'b0 && ((state == SH_READ && sclk_fall_in &&
          count == READ_BITS - 5'h01) || (state == SH_WRITE &&
          sclk_rise_in && count == WRITE_BITS - 5'h01)));
  end

  aux_latch_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (enable_in && state == SH_READ && first_fall && sclk_fall_in)
    |=> shreg[AUX_HIGH_BIT+1 -: 2] == $past(aux_in))
    else $error("aux bits not latched on first falling edge");

  write_len_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (enable_in && state == SH_IDLE && load_write_in && !load_read_in)
    |=> state == SH_WRITE)
    else $error("write access not taken into the discard state");

endmodule

// *** core/adcseq_top.sv ***
// result word assembly, channel selection and scan sequencing
`timescale 1ns/1ps
// What this block does
// - the word leaves msb first: result 17..0, a zero, two aux bits, tag.
// - aux pins are caught on the first falling serial edge of a read.
// - tag 0..3 is input 1..4 vs 6, 4..6 the pairs 1-2 3-4 5-6, 7 cal.
// - with scan on the block steps through every available channel.
// - each scanned channel yields one result before the next one.
// - the scan set follows differential select and the cal mode bits.
// - scan waits for full settling before data ready and switching.
// - settling time follows clock rate, filter and modulator rates.
// - the open sensor test currents follow their own enable bit.
// - both excitation outputs switch together from one enable bit.
// - scan off, normal mode: pair comes from differential and select.
// - input 5 vs 6 pseudo-differential exists only while scanning.
// - scan off, mode 01 picks offset cal, 10 gain cal, else never.
// - in scan, mode 01 or 10 adds the two cal pairs as extra signal channels.
// - the result word is read only; a write still takes eight bits.
// - results are offset binary and clip at the two end codes.
module adcseq_top
  import adcseq_pkg::*;
#(
  parameter int RAW_W = RAW_W_DEF,
  parameter int SETTLE_BASE_CYCLES = SETTLE_BASE_CYC
)
(
  // clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic enable_in,
  // configuration bits
  input wire logic scan_enable_in,
  input wire logic differential_select_in,
  input wire logic cal_mode_bit_high_in,
  input wire logic cal_mode_bit_low_in,
  input wire logic channel_select_high_in,
  input wire logic channel_select_low_in,
  input wire logic clock_rate_in,
  input wire logic [1:0] filter_rate_select_in,
  input wire logic [1:0] modulator_rate_select_in,
  input wire logic open_sensor_test_current_enable_in,
  input wire logic excitation_current_enable_in,
  // converter samples
  input wire logic signed [RAW_W-1:0] raw_sample_in,
  input wire logic raw_valid_in,
  // serial port and command decode
  input wire logic sclk_in,
  input wire logic [1:0] aux_pins_in,
  input wire logic read_start_in,
  input wire logic write_start_in,
  // outputs
  output logic dout_out,
  output logic link_busy_out,
  output logic data_ready_n_out,
  output logic [2:0] mux_pos_out,
  output logic [2:0] mux_neg_out,
  output logic [TAG_W-1:0] source_channel_tag_out,
  output logic open_sensor_test_current_out,
  output logic excitation_output_a_out,
  output logic excitation_output_b_out
);

  initial
  begin
    if (RAW_W < RESULT_W || RAW_W > 31 || SETTLE_BASE_CYCLES < 1 ||
        SETTLE_BASE_CYCLES > 65535)
      $error("adcseq_top: unsupported parameter values");
  end

  localparam logic signed [RAW_W-1:0] SAT_HI = RAW_W'(131071);
  localparam logic signed [RAW_W-1:0] SAT_LO = -RAW_W'(131072);

  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------
  function automatic logic [2:0] chan_pos(adcseq_chan_t c);
    unique case (c)
      CH_P1, CH_D12: chan_pos = PIN_AIN1;
      CH_P2: chan_pos = PIN_AIN2;
      CH_P3, CH_D34: chan_pos = PIN_AIN3;
      CH_P4: chan_pos = PIN_AIN4;
      CH_P5, CH_D56: chan_pos = PIN_AIN5;
      CH_COFF: chan_pos = PIN_CAL_OFF;
      default: chan_pos = PIN_CAL_GAIN;
    endcase
  endfunction

  function automatic logic [2:0] chan_neg(adcseq_chan_t c);
    unique case (c)
      CH_D12: chan_neg = PIN_AIN2;
      CH_D34: chan_neg = PIN_AIN4;
      CH_COFF: chan_neg = PIN_CAL_OFF;
      CH_CGAIN: chan_neg = PIN_CAL_GAIN;
      default: chan_neg = PIN_COMMON;
    endcase
  endfunction

  function automatic logic [TAG_W-1:0] chan_tag(adcseq_chan_t c);
    unique case (c)
      CH_D12: chan_tag = TAG_D12;
      CH_D34: chan_tag = TAG_D34;
      CH_P5, CH_D56: chan_tag = TAG_D56;
      CH_COFF, CH_CGAIN: chan_tag = TAG_CAL;
      default: chan_tag = c[TAG_W-1:0];
    endcase
  endfunction

  function automatic logic [RESULT_W-1:0] clip(logic signed [RAW_W-1:0] r);
    if (r > SAT_HI)
      clip = RESULT_MAX;
    else if (r < SAT_LO)
      clip = RESULT_MIN;
    else
      clip = {~r[RESULT_W-1], r[RESULT_W-2:0]};
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers, three stages, change needs stages two and three
  // ----------------------------------------------------------------
  logic [2:0] sync1, sync2, sync3, agreed;
  logic sclk_fall, sclk_rise;

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      // serial clock idles high, avoids a false edge after reset
      sync1 <= 3'h1;
      sync2 <= 3'h1;
      sync3 <= 3'h1;
      agreed <= 3'h1;
    end
    else if (enable_in)
    begin
      sync1 <= {aux_pins_in, sclk_in};
      sync2 <= sync1;
      sync3 <= sync2;
      agreed <= (sync2 & sync3) | (agreed & (sync2 ^ sync3));
    end
  end

  assign sclk_fall = agreed[0] & ~sync2[0] & ~sync3[0];
  assign sclk_rise = ~agreed[0] & sync2[0] & sync3[0];

  // ----------------------------------------------------------------
  // channel choice
  // ----------------------------------------------------------------
  adcseq_chan_t cur_chan, want_chan, direct_chan, scan_chan;
  adcseq_seq_t state;
  logic [2:0] idx, last_idx;
  logic [1:0] mode;
  logic [23:0] timer, settle_len, since_switch;
  logic capture;

  assign mode = {cal_mode_bit_high_in, cal_mode_bit_low_in};
  assign last_idx = (differential_select_in ? 3'h2 : 3'h4) +
    ((mode == MODE_OFFSET || mode == MODE_GAIN) ? 3'h2 : 3'h0);

  always_comb
  begin
    if (mode == MODE_OFFSET)
      direct_chan = CH_COFF;
    else if (mode == MODE_GAIN)
      direct_chan = CH_CGAIN;
    // normal routing, no AIN5 pseudo here
    else if (differential_select_in)
      direct_chan = adcseq_chan_t'(4'h5 + {2'h0, channel_select_high_in &
        ~channel_select_low_in, channel_select_low_in & ~channel_select_high_in});
    else
      direct_chan = adcseq_chan_t'({2'h0, channel_select_high_in,
        channel_select_low_in});
    // cal pairs close the scan list
    if (differential_select_in)
      scan_chan = adcseq_chan_t'(4'h5 + {1'b0, idx});
    else
      scan_chan = (idx < 3'h5) ? adcseq_chan_t'({1'b0, idx})
        : adcseq_chan_t'(4'h3 + {1'b0, idx});
    want_chan = scan_enable_in ? scan_chan : direct_chan;
  end

  assign settle_len = (24'(SETTLE_BASE_CYCLES) << ({1'b0, filter_rate_select_in}
    + {2'h0, clock_rate_in})) >> modulator_rate_select_in;
  assign capture = enable_in && state == SQ_SAMPLE && raw_valid_in &&
    want_chan == cur_chan;

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      cur_chan <= CH_P1;
      state <= SQ_SETTLE;
      timer <= 24'h000000;
      idx <= 3'h0;
    end
    else if (enable_in)
    begin
      if (!scan_enable_in || idx > last_idx)
        idx <= 3'h0;
      if (want_chan != cur_chan)
      begin
        cur_chan <= want_chan;
        state <= SQ_SETTLE;
        timer <= settle_len;
      end
      else
        unique case (state)
          SQ_SETTLE:
            if (timer <= 24'h000001)
              state <= SQ_SAMPLE;
            else
              timer <= timer - 24'h000001;
          SQ_SAMPLE:
            if (raw_valid_in && scan_enable_in)
              idx <= (idx >= last_idx) ? 3'h0 : idx + 3'h1;
        endcase
    end
  end

  // ----------------------------------------------------------------
  // result word and data ready
  // ----------------------------------------------------------------
  logic [WORD_W-1:0] result_word;
  logic shift_done, read_go, write_go, reading;

  assign read_go = enable_in && read_start_in && !link_busy_out;
  assign write_go = enable_in && write_start_in && !link_busy_out;

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      result_word <= WORD_RESET;
    // word assembly, aux filled during read
    else if (capture)
      result_word <= {clip(raw_sample_in), 1'b0, 2'b00, chan_tag(cur_chan)};
  end

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      data_ready_n_out <= 1'b1;
    // new result wins over the read end
    else if (capture)
      data_ready_n_out <= 1'b0;
    // a write never consumes the pending result
    else if (enable_in && shift_done && reading)
      data_ready_n_out <= 1'b1;
  end

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      reading <= 1'b0;
    else if (read_go)
      reading <= 1'b1;
    else if (write_go || (enable_in && shift_done))
      reading <= 1'b0;
  end

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      mux_pos_out <= PIN_AIN1;
      mux_neg_out <= PIN_COMMON;
      source_channel_tag_out <= 3'h0;
      open_sensor_test_current_out <= 1'b0;
      excitation_output_a_out <= 1'b0;
      excitation_output_b_out <= 1'b0;
    end
    else if (enable_in)
    begin
      mux_pos_out <= chan_pos(cur_chan);
      mux_neg_out <= chan_neg(cur_chan);
      source_channel_tag_out <= chan_tag(cur_chan);
      open_sensor_test_current_out <= open_sensor_test_current_enable_in;
      excitation_output_a_out <= excitation_current_enable_in;
      excitation_output_b_out <= excitation_current_enable_in;
    end
  end

  adcseq_shifter i_adcseq_shifter (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .enable_in(enable_in),
    .load_read_in(read_go),
    .load_write_in(write_go),
    .word_in(result_word),
    .aux_in(agreed[2:1]),
    .sclk_fall_in(sclk_fall),
    .sclk_rise_in(sclk_rise),
    .dout_out(dout_out),
    .busy_out(link_busy_out),
    .done_out(shift_done)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      since_switch <= 24'h000000;
    else if (enable_in)
      since_switch <= (want_chan != cur_chan) ? 24'h000000 :
        (since_switch == 24'hFFFFFF ? since_switch : since_switch + 24'h1);
  end

  first_bit_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    read_go |=> dout_out == $past(result_word[WORD_W-1]))
    else $error("first serial bit is not the result msb");

  tag_field_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    capture |=> result_word[RESERVED_BIT] == 1'b0 &&
    result_word[TAG_W-1:0] == chan_tag($past(cur_chan)))
    else $error("reserved bit or channel tag wrong");

  settle_wait_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    capture |-> since_switch >= settle_len - 24'h1)
    else $error("result captured before settling ended");

  scan_step_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (capture && scan_enable_in && last_idx != 3'h0 && idx <= last_idx)
    |=> idx != $past(idx))
    else $error("scan did not advance after one result");

  cal_select_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (enable_in && !scan_enable_in && mode == MODE_OFFSET) [*3]
    |-> mux_pos_out == PIN_CAL_OFF && mux_neg_out == PIN_CAL_OFF)
    else $error("offset calibration pair not selected");

  no_ain5_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (enable_in && !scan_enable_in && !differential_select_in) [*3]
    |-> mux_pos_out != PIN_AIN5)
    else $error("input five selected without scanning");

  currents_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    enable_in |=> excitation_output_a_out == excitation_output_b_out &&
    open_sensor_test_current_out ==
    $past(open_sensor_test_current_enable_in))
    else $error("current source gates out of step");

  clip_high_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (capture && raw_sample_in > SAT_HI)
    |=> result_word[WORD_W-1 -: RESULT_W] == RESULT_MAX)
    else $error("over-range input did not clip to full scale");

endmodule

// *** tb/adcseq_host.sv ***
// host model: clocks the serial port and collects what the block shifts out
`timescale 1ns/1ps
module adcseq_host
(
  // clock
  input wire logic clk_in,
  // serial side
  input wire logic dout_in,
  output logic sclk_out
);
  // serial clock idles high and stands still between frames
  initial sclk_out = 1'b1;

  // read and write frames clocked whole
  // each bit is taken just before its falling edge, long after the last fall
  task automatic xfer(input int n, output logic [23:0] w);
    w = 24'h000000;
    for (int i = 0; i < n; i++)
    begin
      w = {w[22:0], dout_in};
      @(posedge clk_in);
      sclk_out <= 1'b0;
      repeat (10) @(posedge clk_in);
      sclk_out <= 1'b1;
      repeat (10) @(posedge clk_in);
    end
  endtask
endmodule

// *** tb/tb_top.sv ***
// self-checking bench of the result word and channel sequencer
`timescale 1ns/1ps
module tb_top;
  import adcseq_pkg::*;
  localparam int SB = 8;
  logic clk_in, resetn_in, scan, differential_select, mh, ml, ah, al, cr, osc, exc, rv;
  logic rd, wr, sclk, dout, busy, drdy_n, oso, exa, exb;
  logic [1:0] fs, mf, aux, a;
  logic signed [19:0] raw, v;
  logic [2:0] pos, neg, tag;
  logic [8:0] e, last;
  logic [23:0] w, w0;
  int err_total, checks_done, s, c, q[$];

  adcseq_top #(.RAW_W(20), .SETTLE_BASE_CYCLES(SB)) i_adcseq_top (
    .clk_in(clk_in), .resetn_in(resetn_in), .enable_in(1'b1),
    .scan_enable_in(scan), .differential_select_in(differential_select),
    .cal_mode_bit_high_in(mh), .cal_mode_bit_low_in(ml),
    .channel_select_high_in(ah), .channel_select_low_in(al),
    .clock_rate_in(cr), .filter_rate_select_in(fs),
    .modulator_rate_select_in(mf),
    .open_sensor_test_current_enable_in(osc),
    .excitation_current_enable_in(exc),
    .raw_sample_in(raw), .raw_valid_in(rv), .sclk_in(sclk),
    .aux_pins_in(aux), .read_start_in(rd), .write_start_in(wr),
    .dout_out(dout), .link_busy_out(busy), .data_ready_n_out(drdy_n),
    .mux_pos_out(pos), .mux_neg_out(neg), .source_channel_tag_out(tag),
    .open_sensor_test_current_out(oso), .excitation_output_a_out(exa),
    .excitation_output_b_out(exb));

  adcseq_host i_adcseq_host (.clk_in(clk_in), .dout_in(dout),
    .sclk_out(sclk));

  // channel index 0..4 pseudo, 5..7 pairs, 8 offset cal, 9 gain cal
  function automatic logic [8:0] pinmap(int ch);
    case (ch)
      5: pinmap = {3'h0, 3'h1, TAG_D12};
      6: pinmap = {3'h2, 3'h3, TAG_D34};
      7: pinmap = {3'h4, 3'h5, TAG_D56};
      8: pinmap = {3'h6, 3'h6, TAG_CAL};
      9: pinmap = {3'h7, 3'h7, TAG_CAL};
      default: pinmap = {3'(ch), 3'h5, (ch == 4) ? TAG_D56 : 3'(ch)};
    endcase
  endfunction

  function automatic int fixed_ch();
    if ({mh, ml} == MODE_OFFSET) return 8;
    if ({mh, ml} == MODE_GAIN) return 9;
    return differential_select ? (({ah, al} == 2'h3) ? 5 : 5 + {ah, al}) : {ah, al};
  endfunction

  function automatic logic [17:0] clip(logic signed [19:0] x);
    if (x > 20'sh1FFFF) return 18'h3FFFF;
    if (x < 20'shE0000) return 18'h00000;
    return x[17:0] ^ 18'h20000;
  endfunction

  task automatic chk(input logic [23:0] g, input logic [23:0] x);
    checks_done++;
    if (g !== x)
    begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask

  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // k: 0 busy low, 1 busy high, 2 data ready
  task automatic twait(input int k, input int lim);
    int i;
    for (i = 0; i < lim; i++)
    begin
      @(posedge clk_in);
      if ((k == 0 && busy === 1'b0) || (k == 1 && busy === 1'b1) ||
          (k == 2 && drdy_n === 1'b0))
        break;
    end
    if (i == lim)
    begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, k, lim);
      print_verdict();
    end
  endtask

  task automatic start(input bit is_rd);
    @(posedge clk_in);
    if (is_rd)
      rd <= 1'b1;
    else
      wr <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    wr <= 1'b0;
    twait(1, 4);
  endtask

  task automatic rd_word(output logic [23:0] r);
    start(1'b1);
    i_adcseq_host.xfer(24, r);
    twait(0, 8);
  endtask

  initial
  begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial
  begin
    {scan, differential_select, mh, ml, ah, al, cr, osc, exc, rv, rd, wr} = 12'h000;
    fs = 2'h0;
    mf = 2'h0;
    aux = 2'h0;
    raw = 20'sh00000;
    resetn_in = 1'b0;
    err_total = 0;
    checks_done = 0;
    void'($urandom(32'hC72474F6));
    repeat (5) @(posedge clk_in);
    chk({dout, busy, drdy_n, pos, neg, tag}, {3'h1, 3'h0, 3'h5, 3'h0});
    @(posedge clk_in);
    resetn_in <= 1'b1;
    repeat (40)
    begin
      @(posedge clk_in);
      {differential_select, mh, ml, ah, al, osc, exc} <= 7'($urandom);
      repeat (4) @(posedge clk_in);
      chk({pos, neg, tag}, pinmap(fixed_ch()));
      chk({oso, exa, exb}, {osc, exc, exc});
    end
    $display("test routing done");
    repeat (20) @(posedge clk_in);
    e = pinmap(fixed_ch());
    // saturation corners first, then random samples
    for (int k = 0; k < 8; k++)
    begin
      case (k)
        0: v = 20'sh1FFFF;
        1: v = 20'sh20000;
        2: v = 20'shE0000;
        3: v = 20'shDFFFF;
        default: v = 20'($urandom);
      endcase
      a = 2'($urandom);
      @(posedge clk_in);
      raw <= v;
      rv <= 1'b1;
      aux <= a;
      @(posedge clk_in);
      rv <= 1'b0;
      twait(2, 20);
      fork
        rd_word(w);
        begin
          repeat (40) @(posedge clk_in);
          aux <= ~a;
        end
      join
      chk(w, {clip(v), 1'b0, a, e[2:0]});
      chk({23'h000000, drdy_n}, 24'h000001);
    end
    $display("test read done");
    w0 = w;
    start(1'b0);
    i_adcseq_host.xfer(8, w);
    twait(0, 8);
    rd_word(w);
    chk(w, {w0[23:5], aux, w0[2:0]});
    $display("test write done");
    for (int t = 0; t < 3; t++)
    begin
      @(posedge clk_in);
      scan <= 1'b1;
      differential_select <= (t == 1);
      {mh, ml} <= 2'(t);
      fs <= 2'($urandom);
      mf <= 2'($urandom);
      cr <= 1'($urandom);
      rv <= 1'b1;
      @(posedge clk_in);
      s = (SB << (int'(fs) + int'(cr))) >> mf;
      q.delete();
      for (int i = 0; i < 10; i++)
        if ((t == 1 ? (i > 4 && i < 8) : i < 5) || (i > 7 && t > 0))
          q.push_back(i);
      c = 0;
      while ({pos, neg, tag} !== pinmap(q[0]) && c < 1000)
      begin
        @(posedge clk_in);
        c++;
      end
      chk({pos, neg, tag}, pinmap(q[0]));
      if (c >= 1000)
        print_verdict();
      for (int n = 0; n <= q.size(); n++)
      begin
        last = {pos, neg, tag};
        c = 0;
        while ({pos, neg, tag} === last && c < 1000)
        begin
          @(posedge clk_in);
          c++;
        end
        chk({pos, neg, tag}, pinmap(q[(n + 1) % q.size()]));
        if (n > 0)
          chk(24'(c >= s && c <= s + 6), 24'h000001);
        if (c >= 1000)
          print_verdict();
      end
      @(posedge clk_in);
      rv <= 1'b0;
      scan <= 1'b0;
    end
    $display("test scan done");
    print_verdict();
  end
endmodule
